// file: common/dla_pkg.sv
// Constants, field layouts and carrier types of the doubleword load address unit.
// Assumes one 40 MHz clock and a synchronous active-low reset in every user.
// Contract
// - Address is base register plus optional register or 5-bit unsigned constant offset.
// - Unit bit zero picks first data unit and A file, one picks B file.
// - Destination file bit zero writes A file, one writes B file.
// - Recognised by doubleword flag one and load/store field equal to 110.
// - Destination field is even, so instruction bit 23 is zero.
// - Offset is shifted left by three before add or subtract.
// - Pre and offset modes address the result; post modes address the unmodified base.
// - Mode bits: update base, register offset, post modify, add.
// - Without offset, increments step one unit and plain offsets are zero.
// - Linear arithmetic, circular for bases 4 to 7 as the mode register says.
// - Lower word to even register, upper word to odd register of one file.
// - Bytes of the doubleword are assembled per the endian mode.
// - Little endian: first word to even register; big endian: to odd register.
// - Updated base is visible one cycle after issue; here base_wr is valid one cycle after E1, two cycles after issue.
// - Pair written in the fifth execute phase; address unit busy one cycle.
package dla_pkg;
  // ----------------------------------------------------------------
  // Instruction fields
  // ----------------------------------------------------------------
  localparam int unsigned DST_LSB      = 23;
  localparam int unsigned DST_EVEN_BIT = 23;
  localparam int unsigned BASE_LSB     = 18;
  localparam int unsigned OFS_LSB      = 13;
  localparam int unsigned MODE_LSB     = 9;
  localparam int unsigned DW_BIT       = 8;
  localparam int unsigned UNIT_BIT     = 7;
  localparam int unsigned LDST_LSB     = 4;
  localparam int unsigned DFILE_BIT    = 1;
  localparam logic [2:0]  LDST_DW      = 3'h6;
  localparam logic        DW_FLAG      = 1'h1;
  localparam int unsigned MODE_UPD     = 3;
  localparam int unsigned MODE_REG     = 2;
  localparam int unsigned MODE_POST    = 1;
  localparam int unsigned MODE_ADD     = 0;
  localparam int unsigned SCALE_SHIFT  = 3;
  localparam logic [4:0]  CIRC_FIRST   = 5'h04;
  localparam logic [4:0]  CIRC_LAST    = 5'h07;
  localparam int unsigned DELAY_SLOTS  = 4;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W        = 8;
  localparam logic [7:0]  REG_ADDR_MODE = 8'h00;
  localparam logic [7:0]  REG_CONTROL   = 8'h04;
  localparam logic [7:0]  REG_STATUS    = 8'h08;
  localparam logic [7:0]  REG_LAST_ADDR = 8'h0C;
  localparam int unsigned AM_BSIZE_LSB  = 8;
  localparam int unsigned CTRL_LITTLE   = 0;
  localparam int unsigned ST_ILLEGAL    = 0;
  localparam int unsigned ST_MISALIGN   = 1;
  localparam int unsigned ST_BUSY       = 2;
  localparam logic [31:0] ADDR_MODE_RST = 32'h0000_0000;
  localparam logic [31:0] CONTROL_RST   = 32'h0000_0001;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef struct packed {
    logic        valid;
    logic        file_b;
    logic [4:0]  idx;
    logic [31:0] value;
  } dla_reg_wr_t;

  typedef struct packed {
    logic        valid;
    logic        file_b;
    logic [4:0]  even_idx;
    logic [31:0] even_value;
    logic [31:0] odd_value;
  } dla_pair_wr_t;

  typedef struct packed {
    logic       valid;
    logic       file_b;
    logic [4:0] idx;
    logic       little;
  } dla_ldq_t;
endpackage

// file: hdl/dla_addr_gen.sv
// Address arithmetic for one doubleword load: scaling, add or subtract, circular wrap.
// Assumes the offset is already chosen between register, constant and default.
module dla_addr_gen (
  input  wire logic [31:0] base,
  input  wire logic [31:0] offset,
  input  wire logic [3:0]  mode,
  input  wire logic        circular,
  input  wire logic [4:0]  bsize,
  output logic      [31:0] addr,
  output logic      [31:0] next_base
);
  import dla_pkg::*;

  logic [31:0] step;
  logic [31:0] result;
  logic [31:0] mask;

  always_comb begin
    step   = offset << SCALE_SHIFT;
    // Block is 2^(bsize+1) bytes; only the bits inside it move.
    mask   = (32'h0000_0002 << bsize) - 32'h0000_0001;
    result = mode[MODE_ADD] ? base + step : base - step;
    if (circular) begin
      result = (base & ~mask) | (result & mask);
    end
    addr      = mode[MODE_POST] ? base : result;
    next_base = result;
  end
endmodule

// file: hdl/dla_byte_steer.sv
// Splits a returned doubleword into the even and odd register values.
// Assumes byte 0 of the doubleword, at the lowest address, sits in bits 7:0.
module dla_byte_steer (
  input  wire logic [63:0] rdata,
  input  wire logic        little,
  output logic      [31:0] even_value,
  output logic      [31:0] odd_value
);
  import dla_pkg::*;

  function automatic logic [31:0] swap32(input logic [31:0] w);
    return {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  always_comb begin
    if (little) begin
      even_value = rdata[31:0];
      odd_value  = rdata[63:32];
    end else begin
      odd_value  = swap32(rdata[31:0]);
      even_value = swap32(rdata[63:32]);
    end
  end
endmodule

// file: hdl/dla_top.sv
// Doubleword load address unit: decode, address generation, base update and pair write.
// Assumes register file reads answer in the same cycle and memory data arrives in E4.
//
// Chosen here: the address map and the AXI4-Lite register port.
module dla_top (
  input  wire logic                  clock,
  input  wire logic                  reset_n,
  input  wire logic                  issue_valid,
  input  wire logic [31:0]           issue_instr,
  input  wire logic                  issue_cond_true,
  input  wire logic                  issue_no_offset,
  output logic                       rd_file_b,
  output logic      [4:0]            rd_base_idx,
  output logic      [4:0]            rd_offset_idx,
  input  wire logic [31:0]           rd_base_value,
  input  wire logic [31:0]           rd_offset_value,
  output dla_pkg::dla_reg_wr_t       base_wr,
  output logic                       mem_req,
  output logic      [31:0]           mem_addr,
  input  wire logic [63:0]           mem_rdata,
  output dla_pkg::dla_pair_wr_t      dst_wr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [dla_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  output logic      [1:0]            s_axi_bresp,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  input  wire logic [dla_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic      [31:0]           s_axi_rdata,
  output logic      [1:0]            s_axi_rresp
);
  import dla_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic              is_dw;
  logic              dw_ok;
  logic              e1_valid;
  logic              e1_pred;
  logic              e1_no_ofs;
  logic              e1_little;
  logic              e1_dfile_b;
  logic [3:0]        e1_mode;
  logic [4:0]        e1_dst;
  logic [4:0]        e1_const;
  logic              fire;
  logic              circular;
  logic [31:0]       offset;
  logic [31:0]       agen_addr;
  logic [31:0]       agen_next;
  logic [31:0]       even_value;
  logic [31:0]       odd_value;
  dla_ldq_t          ldq [DELAY_SLOTS-1];
  logic [31:0]       addr_mode;
  logic [31:0]       control;
  logic              st_illegal;
  logic              st_misalign;
  logic              busy;
  logic [31:0]       last_addr;
  logic              aw_full;
  logic              w_full;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              aw_hs;
  logic              w_hs;
  logic              ar_hs;
  logic              do_write;
  logic              set_illegal;
  logic              set_misalign;
  logic              clr_status;
  logic [31:0]       read_mux;
  logic              read_ok;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Decode and first execute phase
  // ----------------------------------------------------------------
  assign is_dw = issue_valid && (issue_instr[DW_BIT] == DW_FLAG)
                 && (issue_instr[LDST_LSB +: 3] == LDST_DW);
  assign dw_ok = is_dw && !issue_instr[DST_EVEN_BIT];
  assign set_illegal = is_dw && issue_instr[DST_EVEN_BIT];

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      e1_valid      <= 1'h0;
      e1_pred       <= 1'h0;
      e1_no_ofs     <= 1'h0;
      e1_little     <= 1'h0;
      e1_dfile_b    <= 1'h0;
      e1_mode       <= 4'h0;
      e1_dst        <= 5'h00;
      e1_const      <= 5'h00;
      rd_file_b     <= 1'h0;
      rd_base_idx   <= 5'h00;
      rd_offset_idx <= 5'h00;
    end else begin
      e1_valid <= dw_ok;
      e1_pred  <= issue_cond_true;
      if (dw_ok) begin
        e1_no_ofs     <= issue_no_offset;
        e1_little     <= control[CTRL_LITTLE];
        e1_dfile_b    <= issue_instr[DFILE_BIT];
        e1_mode       <= issue_instr[MODE_LSB +: 4];
        e1_dst        <= issue_instr[DST_LSB +: 5];
        e1_const      <= issue_instr[OFS_LSB +: 5];
        rd_file_b     <= issue_instr[UNIT_BIT];
        rd_base_idx   <= issue_instr[BASE_LSB +: 5];
        rd_offset_idx <= issue_instr[OFS_LSB +: 5];
      end
    end
  end

  assign fire = e1_valid && e1_pred;
  assign circular = (rd_base_idx >= CIRC_FIRST) && (rd_base_idx <= CIRC_LAST)
                    && addr_mode[{rd_file_b, rd_base_idx[1:0]}];

  always_comb begin
    if (e1_no_ofs) begin
      offset = {31'h0000_0000, e1_mode[MODE_UPD]};
    end else if (e1_mode[MODE_REG]) begin
      offset = rd_offset_value;
    end else begin
      offset = {27'h000_0000, e1_const};
    end
  end

  dla_addr_gen u_agen (
    .base      (rd_base_value),
    .offset    (offset),
    .mode      (e1_mode),
    .circular  (circular),
    .bsize     (addr_mode[AM_BSIZE_LSB +: 5]),
    .addr      (agen_addr),
    .next_base (agen_next)
  );

  // ----------------------------------------------------------------
  // Base update and memory request
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      base_wr  <= '0;
      mem_req  <= 1'h0;
      mem_addr <= 32'h0000_0000;
    end else begin
      base_wr.valid <= fire && e1_mode[MODE_UPD];
      base_wr.file_b <= rd_file_b;
      base_wr.idx    <= rd_base_idx;
      base_wr.value  <= agen_next;
      mem_req <= fire;
      if (fire) begin
        mem_addr <= agen_addr;
      end
    end
  end

  // ----------------------------------------------------------------
  // Load pipeline and pair write
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      for (int i = 0; i < DELAY_SLOTS - 1; i++) begin
        ldq[i] <= '0;
      end
    end else begin
      ldq[0] <= '{valid: fire, file_b: e1_dfile_b, idx: e1_dst, little: e1_little};
      for (int i = 1; i < DELAY_SLOTS - 1; i++) begin
        ldq[i] <= ldq[i-1];
      end
    end
  end

  dla_byte_steer u_steer (
    .rdata      (mem_rdata),
    .little     (ldq[DELAY_SLOTS-2].little),
    .even_value (even_value),
    .odd_value  (odd_value)
  );

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      dst_wr <= '0;
    end else begin
      dst_wr.valid      <= ldq[DELAY_SLOTS-2].valid;
      dst_wr.file_b     <= ldq[DELAY_SLOTS-2].file_b;
      dst_wr.even_idx   <= ldq[DELAY_SLOTS-2].idx;
      dst_wr.even_value <= even_value;
      dst_wr.odd_value  <= odd_value;
    end
  end

  // ----------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------
  assign set_misalign = fire && (agen_addr[2:0] != 3'h0);
  assign clr_status = do_write && (aw_addr == REG_STATUS) && w_strb[0];

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      st_illegal  <= 1'h0;
      st_misalign <= 1'h0;
      busy        <= 1'h0;
      last_addr   <= 32'h0000_0000;
    end else begin
      // A new event in the clearing cycle wins over the clear.
      st_illegal  <= set_illegal || (st_illegal && !(clr_status && w_data[ST_ILLEGAL]));
      st_misalign <= set_misalign || (st_misalign && !(clr_status && w_data[ST_MISALIGN]));
      busy        <= e1_valid || ldq[0].valid || ldq[1].valid || ldq[2].valid;
      if (fire) begin
        last_addr <= agen_addr;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  assign aw_hs    = s_axi_awvalid && s_axi_awready;
  assign w_hs     = s_axi_wvalid && s_axi_wready;
  assign ar_hs    = s_axi_arvalid && s_axi_arready;
  assign do_write = aw_full && w_full && !s_axi_bvalid;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      aw_full       <= 1'h0;
      w_full        <= 1'h0;
      aw_addr       <= '0;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'h0;
      s_axi_wready  <= 1'h0;
    end else begin
      aw_full       <= (aw_full || aw_hs) && !do_write;
      w_full        <= (w_full || w_hs) && !do_write;
      s_axi_awready <= !((aw_full || aw_hs) && !do_write);
      s_axi_wready  <= !((w_full || w_hs) && !do_write);
      if (aw_hs) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      addr_mode    <= ADDR_MODE_RST;
      control      <= CONTROL_RST;
      s_axi_bvalid <= 1'h0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (do_write) begin
        s_axi_bvalid <= 1'h1;
        s_axi_bresp  <= RESP_OKAY;
        unique case (aw_addr)
          REG_ADDR_MODE: addr_mode <= merge(addr_mode, w_data, w_strb);
          REG_CONTROL:   control <= merge(control, w_data, w_strb);
          REG_STATUS, REG_LAST_ADDR: ;
          default:       s_axi_bresp <= RESP_SLVERR;
        endcase
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'h0;
      end
    end
  end

  always_comb begin
    read_ok = 1'h1;
    unique case (s_axi_araddr)
      REG_ADDR_MODE: read_mux = addr_mode;
      REG_CONTROL:   read_mux = control;
      REG_STATUS:    read_mux = {29'h0000_0000, busy, st_misalign, st_illegal};
      REG_LAST_ADDR: read_mux = last_addr;
      default: begin
        read_mux = 32'h0000_0000;
        read_ok  = 1'h0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s_axi_arready <= 1'h0;
      s_axi_rvalid  <= 1'h0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !(ar_hs || (s_axi_rvalid && !s_axi_rready));
      if (ar_hs) begin
        s_axi_rvalid <= 1'h1;
        s_axi_rdata  <= read_mux;
        s_axi_rresp  <= read_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  chk_decode_match: assert property (
    e1_valid |-> $past(issue_instr[LDST_LSB +: 3]) == LDST_DW && $past(issue_instr[DW_BIT]))
    else $error("E1 holds an instruction that is not a doubleword load.");
  chk_even_dest: assert property (
    dst_wr.valid |-> !dst_wr.even_idx[0])
    else $error("Pair write to an odd register number.");
  chk_base_early: assert property (
    fire && e1_mode[MODE_UPD] |=> base_wr.valid && base_wr.idx == $past(rd_base_idx))
    else $error("Base update not visible one cycle after E1.");
  chk_pair_fifth: assert property (
    mem_req |-> ##3 dst_wr.valid)
    else $error("Pair not written in the fifth phase.");
  chk_false_pred: assert property (
    e1_valid && !e1_pred |=> !mem_req && !base_wr.valid ##3 !dst_wr.valid)
    else $error("Predicated-off load had an effect.");
  chk_post_addr: assert property (
    fire && e1_mode[MODE_POST] |=> mem_addr == $past(rd_base_value))
    else $error("Post-modify did not address the old base.");
  chk_scaled_ofs: assert property (
    fire && !circular && !e1_no_ofs && e1_mode[MODE_REG] && e1_mode[MODE_ADD] && !e1_mode[MODE_POST]
    |=> mem_addr == $past(rd_base_value) + ($past(rd_offset_value) << 3))
    else $error("Register offset not scaled by eight.");
  chk_little_even: assert property (
    ldq[DELAY_SLOTS-2].valid && ldq[DELAY_SLOTS-2].little
    |=> dst_wr.even_value == $past(mem_rdata[31:0]))
    else $error("Little-endian first word not in the even register.");
  chk_dst_file: assert property (
    fire |-> ##4 dst_wr.file_b == $past(e1_dfile_b, 4))
    else $error("Pair written to the wrong register file.");

  cov_load_done: cover property (mem_req ##3 dst_wr.valid);
  cov_base_upd:  cover property (base_wr.valid ##2 dst_wr.valid);
  cov_circular:  cover property (fire && circular);
  cov_big_end:   cover property (ldq[DELAY_SLOTS-2].valid && !ldq[DELAY_SLOTS-2].little);
endmodule

// file: verif/dla_mem_model.sv
// Behavioural data memory that answers the doubleword load unit.
// Assumes at most one request per cycle; data follows two cycles after it.
module dla_mem_model (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  output logic      [63:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        req_d;
  logic [31:0] addr_d;
  always @(posedge clock) begin
    req_d <= mem_req & reset_n;
    addr_d <= mem_addr;
    // Outside the answer cycle and reset the lines toggle, so stale data never passes for an answer.
    if (!reset_n) begin
      mem_rdata <= 64'h0F0F_0F0F_0F0F_0F0F;
    end else if (req_d) begin
      mem_rdata <= {addr_d ^ 32'hA5A5_0F0F, ~addr_d};
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// file: verif/doubleword_load_agu_tb.sv
// Self-checking bench of the doubleword load address unit.
// Assumes dla_mem_model answers two cycles after each memory request.
module doubleword_load_agu_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dla_pkg::*;
  typedef struct packed {
    logic        go, upd, rofs, y, s, little;
    logic [4:0]  bi, oi, di;
    logic [31:0] addr, nb;
  } dla_exp_t;
  logic         clock = 1'h0, reset_n = 1'h0;
  logic         issue_valid = 1'h0, issue_cond_true = 1'h0, issue_no_offset = 1'h0;
  logic [31:0]  issue_instr = 32'h0, s_axi_wdata = 32'h0, am = 32'h0;
  logic         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic         s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, ctl_little = 1'h1;
  logic [7:0]   s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [3:0]   s_axi_wstrb = 4'h0;
  logic         rd_file_b, mem_req, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [4:0]   rd_base_idx, rd_offset_idx;
  logic [31:0]  rd_base_value, rd_offset_value, mem_addr, s_axi_rdata, ev, od;
  logic [1:0]   s_axi_bresp, s_axi_rresp, resp;
  logic [63:0]  mem_rdata, dx;
  dla_reg_wr_t  base_wr;
  dla_pair_wr_t dst_wr;
  dla_exp_t     pipe [1:5];
  logic [3:0]   modes [12] = '{4'h5, 4'h4, 4'hD, 4'hC, 4'hF, 4'hE, 4'h1, 4'h0, 4'h9, 4'h8, 4'hB, 4'hA};
  int           n_fail = 0, checks_done = 0, cyc = 0;

  dla_top dut (.clock, .reset_n, .issue_valid, .issue_instr, .issue_cond_true, .issue_no_offset,
    .rd_file_b, .rd_base_idx, .rd_offset_idx, .rd_base_value, .rd_offset_value, .base_wr, .mem_req,
    .mem_addr, .mem_rdata, .dst_wr, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp);
  dla_mem_model mem (.clock, .reset_n, .mem_req, .mem_addr, .mem_rdata);

  always #12.5 clock = ~clock;

  // ----------------------------------------------------------------
  // Register file and expectation model
  // ----------------------------------------------------------------
  function automatic logic [31:0] base_of(logic y, logic [4:0] i);
    return {23'h0, y, i, 3'h0} + 32'h0000_1000;
  endfunction
  assign rd_base_value = base_of(rd_file_b, rd_base_idx);
  assign rd_offset_value = {26'h0, rd_file_b, rd_offset_idx} + 32'h3;

  function automatic logic [31:0] bsw(logic [31:0] x);
    return {x[7:0], x[15:8], x[23:16], x[31:24]};
  endfunction
  function automatic logic [31:0] mk(logic [4:0] d, b, o, logic [3:0] m, logic y, s);
    return {4'h0, d, b, o, m, 1'h1, y, 3'h6, 2'h0, s, 1'h0};
  endfunction

  function automatic dla_exp_t exp_of(logic [31:0] in, logic c, logic no);
    dla_exp_t    e;
    logic [31:0] b, o, m;
    e.go = c && in[8] && in[6:4] == 3'h6 && !in[23];
    {e.upd, e.rofs} = in[12:11];
    {e.y, e.s, e.little} = {in[7], in[1], ctl_little};
    {e.bi, e.oi, e.di} = {in[22:18], in[17:13], in[27:23]};
    b = base_of(e.y, e.bi);
    o = e.rofs ? {26'h0, e.y, e.oi} + 32'h3 : {27'h0, e.oi};
    if (no) o = {31'h0, in[12]};
    o = o << 3;
    e.nb = in[9] ? b + o : b - o;
    if (e.bi >= CIRC_FIRST && e.bi <= CIRC_LAST && am[{e.y, e.bi[1:0]}]) begin
      m = (32'h2 << am[12:8]) - 32'h1;
      e.nb = (b & ~m) | (e.nb & m);
    end
    e.addr = in[10] ? b : e.nb;
    return e;
  endfunction

  // ----------------------------------------------------------------
  // Checks, tasks and closing
  // ----------------------------------------------------------------
  task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      end_sim();
    end
  end

  always @(posedge clock) begin
    if (!reset_n) begin
      for (int k = 1; k <= 5; k++) pipe[k] = '0;
    end else begin
      if (pipe[1].go) begin
        cmp("rd_base", {pipe[1].y, pipe[1].bi}, {rd_file_b, rd_base_idx});
        if (pipe[1].rofs) cmp("rd_offset_idx", pipe[1].oi, rd_offset_idx);
      end
      cmp("mem_req", pipe[2].go, mem_req);
      cmp("base_wr.valid", pipe[2].go & pipe[2].upd, base_wr.valid);
      if (pipe[2].go) cmp("mem_addr", pipe[2].addr, mem_addr);
      if (pipe[2].go & pipe[2].upd)
        cmp("base_wr", {pipe[2].y, pipe[2].bi, pipe[2].nb}, {base_wr.file_b, base_wr.idx, base_wr.value});
      cmp("dst_wr.valid", pipe[5].go, dst_wr.valid);
      if (pipe[5].go) begin
        dx = {pipe[5].addr ^ 32'hA5A5_0F0F, ~pipe[5].addr};
        ev = pipe[5].little ? dx[31:0] : bsw(dx[63:32]);
        od = pipe[5].little ? dx[63:32] : bsw(dx[31:0]);
        cmp("dst_wr pair", {ev, od}, {dst_wr.even_value, dst_wr.odd_value});
        cmp("dst_wr place", {pipe[5].s, pipe[5].di}, {dst_wr.file_b, dst_wr.even_idx});
      end
      for (int k = 5; k > 1; k--) pipe[k] = pipe[k-1];
      pipe[1] = issue_valid ? exp_of(issue_instr, issue_cond_true, issue_no_offset) : '0;
    end
  end

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b;
    {aw, w, b} = 3'h7;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hF};
    while (b) begin
      @(posedge clock);
      if (aw && s_axi_awready === 1'h1) begin
        aw = 1'h0;
        s_axi_awvalid <= 1'h0;
      end
      if (w && s_axi_wready === 1'h1) begin
        w = 1'h0;
        s_axi_wvalid <= 1'h0;
      end
      if (s_axi_bvalid === 1'h1) begin
        b = 1'h0;
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
      end
    end
    // One idle edge keeps the release apart from the next request.
    @(posedge clock);
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic busy;
    busy = 1'h1;
    {s_axi_arvalid, s_axi_rready, s_axi_araddr} <= {2'h3, a};
    while (busy) begin
      @(posedge clock);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid === 1'h1) begin
        busy = 1'h0;
        cmp("rdata", e, s_axi_rdata);
        cmp("rresp", er, s_axi_rresp);
        s_axi_rready <= 1'h0;
      end
    end
    @(posedge clock);
  endtask

  task automatic issue(input logic [31:0] ins, input logic c, input logic no);
    {issue_valid, issue_cond_true, issue_no_offset, issue_instr} <= {1'h1, c, no, ins};
    @(posedge clock);
  endtask

  initial begin
    repeat (5) @(posedge clock);
    reset_n <= 1'h1;
    repeat (2) @(posedge clock);
    chk_rd(REG_ADDR_MODE, ADDR_MODE_RST, RESP_OKAY);
    chk_rd(REG_CONTROL, CONTROL_RST, RESP_OKAY);
    chk_rd(8'h40, 32'h0, RESP_SLVERR);
    axi_wr(8'h40, 32'h1, resp);
    cmp("bresp", RESP_SLVERR, resp);
    for (int i = 0; i < 12; i++) issue(mk(5'(2*i), 5'(8+i), 5'(i+1), modes[i], i[0], i[1]), 1'h1, 1'h0);
    issue(mk(5'h2, 5'h9, 5'h0, 4'hD, 1'h0, 1'h1), 1'h1, 1'h1);
    issue(mk(5'h4, 5'hA, 5'h0, 4'h5, 1'h1, 1'h0), 1'h1, 1'h1);
    issue(mk(5'h6, 5'hB, 5'h2, 4'hD, 1'h0, 1'h0), 1'h0, 1'h0);
    issue(mk(5'h8, 5'hC, 5'h2, 4'hD, 1'h0, 1'h0) ^ 32'h40, 1'h1, 1'h0);
    issue(mk(5'hA, 5'hC, 5'h2, 4'hD, 1'h0, 1'h0) ^ 32'h100, 1'h1, 1'h0);
    issue(mk(5'h3, 5'hD, 5'h2, 4'hD, 1'h1, 1'h0), 1'h1, 1'h0);
    issue_valid <= 1'h0;
    repeat (8) @(posedge clock);
    chk_rd(REG_STATUS, 32'h1, RESP_OKAY);
    axi_wr(REG_STATUS, 32'h1, resp);
    chk_rd(REG_STATUS, 32'h0, RESP_OKAY);
    axi_wr(REG_CONTROL, 32'h0, resp);
    ctl_little = 1'h0;
    axi_wr(REG_ADDR_MODE, 32'h0000_0401, resp);
    am = 32'h0000_0401;
    // The step of 40 bytes leaves the 32-byte block, so the wrap is visible.
    issue(mk(5'h4, 5'h4, 5'h5, 4'hB, 1'h0, 1'h1), 1'h1, 1'h0);
    issue(mk(5'h6, 5'h4, 5'h3, 4'hB, 1'h1, 1'h0), 1'h1, 1'h0);
    issue(mk(5'h8, 5'h5, 5'h2, 4'hF, 1'h0, 1'h0), 1'h1, 1'h0);
    issue_valid <= 1'h0;
    repeat (8) @(posedge clock);
    chk_rd(REG_LAST_ADDR, 32'h0000_1028, RESP_OKAY);
    end_sim();
  end
endmodule
